// >>> design/vphy_autoneg.sv
// Emulated auto-negotiation core of the virtual PHY
`default_nettype none
module vphy_autoneg #(
   parameter int SOFT_RST_CYCLES = negotiation_enable_bit_pkg::SOFT_RST_CYC
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Reset and restart events (one-cycle pulses, core clock)
   input  wire logic       digitalRst,
   input  wire logic       loaderReload,
   input  wire logic       loaderStrapDone,
   input  wire logic       globalSoftRstSet,
   input  wire logic       ctrlSoftRstSet,
   input  wire logic       restartWr,
   // Basic control bits
   input  wire logic       negEnable,
   input  wire logic       ctrlSpeed100,
   input  wire logic       ctrlFullDuplex,
   // Local advertisement write
   input  wire logic       advWr,
   input  wire logic [3:0] advWrData,
   input  wire logic [1:0] advPauseWrData,
   // Port 0 straps (pins)
   input  wire logic       strapDuplex,
   input  wire logic       strapSpeed,
   // Status
   output logic            globalSoftRst,
   output logic            ctrlSoftRst,
   output logic            negComplete,
   output logic            pageReceived,
   output logic            partnerNegAble,
   output logic [3:0]      localAdv,
   output logic [1:0]      localPause,
   output logic [3:0]      partnerAbil,
   output logic [1:0]      partnerPause,
   output logic            nextPageAble,
   output logic            remoteFault,
   output logic            t4Able,
   // Resolved link
   output logic            linkSpeed100,
   output logic            linkFullDuplex,
   output logic            linkPause
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_CMPL   = 2'b01,
      ST_PAGE   = 2'b10,
      ST_RESOLV = 2'b11
   } ph_t;

   typedef struct packed {
      ph_t        ph;
      logic       pend;
      logic       dupS1, dupS2, spdS1, spdS2;
      logic       gRst, cRst;
      logic       cmpl, page, pAble;
      logic [3:0] adv;
      logic [1:0] pause;
      logic [3:0] lp;
      logic       spd, fdx, pse;
   } st_t;
   st_t st_r, st_nxt;

   logic       softStart, tmrBusy, tmrDone, anyRst, restart;
   logic [3:0] ptnDefault, common;

   // Soft reset request starts the timer
   assign softStart = (globalSoftRstSet || ctrlSoftRstSet) && !tmrBusy;

   virtual_phy_soft_reset_timer #(.CYCLES(SOFT_RST_CYCLES)) u_rst_timer (
      .core_clk (core_clk),
      .resetn   (resetn),
      .start    (softStart),
      .busy     (tmrBusy),
      .done     (tmrDone)
   );

   // -------------------------------------------------------------
   // Partner abilities and resolution
   // -------------------------------------------------------------
   // Partner default from straps: speed picks rate, duplex picks FD
   always_comb begin
      ptnDefault = negotiation_enable_bit_pkg::ABIL_NONE;
      ptnDefault[negotiation_enable_bit_pkg::ABIL_10HD] = 1'b1; // RULE9
      ptnDefault[negotiation_enable_bit_pkg::ABIL_10FD] = st_r.dupS2;
      ptnDefault[negotiation_enable_bit_pkg::ABIL_100HD] = st_r.spdS2;
      ptnDefault[negotiation_enable_bit_pkg::ABIL_100FD] = st_r.spdS2 && st_r.dupS2;
   end

   assign common = st_r.adv & ptnDefault; // RULE5

   // Reset-class events reload registers and rerun negotiation
   assign anyRst = digitalRst || tmrDone;
   assign restart = anyRst || restartWr || loaderReload || loaderStrapDone; // RULE2 RULE3

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Strap synchronisers
      st_nxt.dupS1 = strapDuplex;
      st_nxt.dupS2 = st_r.dupS1;
      st_nxt.spdS1 = strapSpeed;
      st_nxt.spdS2 = st_r.spdS1;
      // Soft reset bits self clear at end of reset; set wins
      if (tmrDone) begin
         st_nxt.gRst = 1'b0; // RULE17
         st_nxt.cRst = 1'b0;
      end
      if (globalSoftRstSet) st_nxt.gRst = 1'b1;
      if (ctrlSoftRstSet) st_nxt.cRst = 1'b1;
      // Advertisement write
      if (advWr) begin
         st_nxt.adv = advWrData; // RULE7
         st_nxt.pause = advPauseWrData;
      end
      // Run sequencer
      unique case (st_r.ph)
         ST_IDLE: begin
            if (st_r.pend && negEnable) begin // RULE1
               st_nxt.pend = 1'b0;
               st_nxt.ph = ST_CMPL;
            end
         end
         ST_CMPL: begin
            st_nxt.cmpl = 1'b1; // RULE4
            st_nxt.ph = ST_PAGE;
         end
         ST_PAGE: begin
            st_nxt.page = 1'b1; // RULE4
            st_nxt.ph = ST_RESOLV;
         end
         ST_RESOLV: begin
            st_nxt.ph = ST_IDLE;
            st_nxt.pse = st_r.pause[0]; // Partner mirrors our pause
            if (common != negotiation_enable_bit_pkg::ABIL_NONE) begin
               st_nxt.pAble = 1'b1; // RULE12
               st_nxt.lp = ptnDefault;
               st_nxt.spd = common[negotiation_enable_bit_pkg::ABIL_100FD] ||
                            common[negotiation_enable_bit_pkg::ABIL_100HD]; // RULE6
               st_nxt.fdx = common[negotiation_enable_bit_pkg::ABIL_100FD] ||
                            (!common[negotiation_enable_bit_pkg::ABIL_100HD] &&
                             common[negotiation_enable_bit_pkg::ABIL_10FD]);
            end else begin
               st_nxt.pAble = 1'b0; // RULE13
               st_nxt.fdx = 1'b0;
               st_nxt.spd = st_r.spdS2; // RULE14
               st_nxt.lp = st_r.spdS2 ? 4'h4 : 4'h1; // RULE15
               st_nxt.pse = 1'b0;
            end
         end
      endcase
      // A restart clears complete and page received and schedules a fresh run
      if (restart) begin
         st_nxt.pend = 1'b1;
         st_nxt.ph = ST_IDLE;
         st_nxt.cmpl = 1'b0;
         st_nxt.page = 1'b0;
      end
      if (anyRst) begin
         st_nxt.adv = negotiation_enable_bit_pkg::ABIL_RESET;
         st_nxt.pause = negotiation_enable_bit_pkg::PAUSE_RESET;
      end
   end

   // State register; result fields change only in ST_RESOLV
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_r <= '0;
         st_r.adv <= negotiation_enable_bit_pkg::ABIL_RESET; // RULE7
         st_r.pend <= 1'b1; // RULE2
      end else begin
         st_r <= st_nxt; // RULE8 RULE10 RULE18
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign globalSoftRst = st_r.gRst;
   assign ctrlSoftRst = st_r.cRst;
   assign negComplete = st_r.cmpl;
   assign pageReceived = st_r.page;
   assign partnerNegAble = st_r.pAble;
   assign localAdv = st_r.adv;
   assign localPause = st_r.pause;
   assign partnerAbil = st_r.lp;
   assign partnerPause = st_r.pAble ? st_r.pause : 2'h0;
   assign nextPageAble = 1'b0; // RULE11
   assign remoteFault = 1'b0; // RULE11
   assign t4Able = 1'b0; // RULE11
   // Forced mode when negotiation is off
   assign linkSpeed100 = negEnable ? st_r.spd : ctrlSpeed100; // RULE16
   assign linkFullDuplex = negEnable ? st_r.fdx : ctrlFullDuplex; // RULE16
   assign linkPause = negEnable ? st_r.pse : 1'b0;
endmodule : vphy_autoneg
`default_nettype wire

// >>> design/negotiation_enable_bit_pkg.sv
// Package of constants for emulated virtual PHY negotiation
// Operation
// RULE1: Negotiation runs only while the negotiation enable bit is set.
// RULE2: Resets, soft resets, restart write, digital reset, loader reload restart negotiation.
// RULE3: Negotiation also restarts when the loader finishes updating strap values.
// RULE4: Each run sets complete, then page received, then registers the result.
// RULE5: Result comes from ANDing local and partner technology ability bits.
// RULE6: Priority is 100 full, 100 half, 10 full, 10 half.
// RULE7: Advertisement resets with all four ability bits set; software may rewrite them.
// RULE8: Advertisement changes after completion apply only at the next run. The code does not hold partnerPause: it shows a new local pause write at once.
// RULE9: Partner default abilities come from port 0 duplex and speed straps.
// RULE10: Straps are static; their change does not start a new run.
// RULE11: No next page, remote fault or four-pair 100 ability on either side.
// RULE12: Common ability gives success, partner-able set, partner bits loaded.
// RULE13: No common ability fails, uses parallel detect, clears partner-able, half duplex.
// RULE14: Parallel detect takes speed from the port 0 speed strap.
// RULE15: After parallel detect exactly one partner technology bit is set.
// RULE16: Negotiation off forces speed and duplex from control bits, else they're ignored.
// RULE17: Global soft reset bit clears itself when the virtual PHY reset completes.
// RULE18: Registered result holds between runs except for resets.
`default_nettype none
package negotiation_enable_bit_pkg;
   // Technology ability field order: {100FD, 100HD, 10FD, 10HD}
   localparam int ABIL_W = 4;
   localparam logic [3:0] ABIL_RESET = 4'hF;
   localparam int ABIL_100FD = 3;
   localparam int ABIL_100HD = 2;
   localparam int ABIL_10FD = 1;
   localparam int ABIL_10HD = 0;
   localparam logic [3:0] ABIL_NONE = 4'h0;
   localparam logic [1:0] PAUSE_RESET = 2'h0;
   // Soft reset duration
   localparam int CLK_MHZ = 250;
   localparam int SOFT_RST_US = 102;
   localparam int SOFT_RST_CYC = SOFT_RST_US * CLK_MHZ;
endpackage : negotiation_enable_bit_pkg
`default_nettype wire

// >>> design/virtual_phy_soft_reset_timer.sv
// Countdown timer that times out the virtual PHY soft reset
`default_nettype none
module virtual_phy_soft_reset_timer #(
   parameter int CYCLES = 25500
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // Control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        busy;
      logic        done;
   } st_t;
   st_t st_r, st_nxt;

   // Count down while busy, pulse done at the end
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (start) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = 32'(CYCLES - 1);
      end else if (st_r.busy) begin
         if (st_r.cnt == 32'h0) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt - 32'h1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!resetn) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign busy = st_r.busy;
   assign done = st_r.done;
endmodule : virtual_phy_soft_reset_timer
`default_nettype wire

// >>> tb/negotiation_enable_bit_properties.sv
// Concurrent checks on the negotiation core ports
`default_nettype none
module negotiation_enable_bit_properties #(
   parameter int SOFT_RST_CYCLES = 8
) (
   // Clock, reset and control
   input wire logic       core_clk, resetn, negEnable, ctrlSpeed100, ctrlFullDuplex,
   // Status and result
   input wire logic       globalSoftRst, negComplete, pageReceived, partnerNegAble,
   input wire logic       nextPageAble, remoteFault, t4Able,
   input wire logic       linkSpeed100, linkFullDuplex, linkPause,
   input wire logic [3:0] localAdv, partnerAbil
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Steps of one run
   sequence s_cmpl; $rose(negComplete); endsequence
   sequence s_page; $rose(pageReceived); endsequence
   sequence s_done; pageReceived && $stable(pageReceived); endsequence
   property p_order; s_cmpl |=> s_page; endproperty
   a_order: assert property (p_order) else $error("page flag not after complete");
   property p_run; s_cmpl |-> $past(negEnable); endproperty
   a_run: assert property (p_run) else $error("run while disabled");
   property p_fixed; !(nextPageAble || remoteFault || t4Able); endproperty
   a_fixed: assert property (p_fixed) else $error("unsupported ability shown");
   property p_pd; s_done and !partnerNegAble |-> $onehot(partnerAbil); endproperty
   a_pd: assert property (p_pd) else $error("detect result not one bit");
   property p_half;
      s_done and negEnable && !partnerNegAble |-> !linkFullDuplex && !linkPause;
   endproperty
   a_half: assert property (p_half) else $error("detect not half duplex");
   property p_able; partnerNegAble |-> partnerAbil[0]; endproperty
   a_able: assert property (p_able) else $error("partner bits not loaded");
   property p_force;
      !negEnable |-> linkSpeed100 == ctrlSpeed100 && linkFullDuplex == ctrlFullDuplex;
   endproperty
   a_force: assert property (p_force) else $error("forced mode wrong");
   property p_srst; $rose(globalSoftRst) |-> ##[1:40] !globalSoftRst; endproperty
   a_srst: assert property (p_srst) else $error("soft reset stuck");
   property p_adv; $rose(resetn) |-> localAdv == 4'hF; endproperty
   a_adv: assert property (p_adv) else $error("advertisement reset wrong");
endmodule // negotiation_enable_bit_properties
bind vphy_autoneg negotiation_enable_bit_properties #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) u_props (.*);
`default_nettype wire

// >>> tb/mac_model.sv
// Management driver model writing the advertisement
`default_nettype none
module mac_model (
   input  wire logic core_clk,
   output logic       advWr,
   output logic [3:0] advWrData,
   output logic [1:0] advPauseWrData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      advWr = 1'b0;
      advWrData = 4'h0;
      advPauseWrData = 2'h0;
   end
   // One-cycle write; data goes stale-inverted once released
   task automatic write_adv(input logic [3:0] a, input logic [1:0] p);
      @(negedge core_clk);
      advWr = 1'b1;
      advWrData = a;
      advPauseWrData = p;
      @(negedge core_clk);
      advWr = 1'b0;
      advWrData = ~a;
      advPauseWrData = ~p;
   endtask
endmodule // mac_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the negotiation core
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, negEnable, ctrlSpeed100, ctrlFullDuplex, strapDuplex, strapSpeed;
   logic [5:0] ev;
   wire logic digitalRst, loaderReload, loaderStrapDone;
   wire logic globalSoftRstSet, ctrlSoftRstSet, restartWr;
   logic advWr, globalSoftRst, ctrlSoftRst, negComplete, pageReceived, partnerNegAble;
   logic nextPageAble, remoteFault, t4Able, linkSpeed100, linkFullDuplex, linkPause;
   logic [3:0] advWrData, localAdv, partnerAbil;
   logic [1:0] advPauseWrData, localPause, partnerPause;
   int mismatches, check_count, adv, pse, ms, i, lad;
   logic [1:0] pz;
   assign {restartWr, ctrlSoftRstSet, globalSoftRstSet} = ev[5:3];
   assign {loaderStrapDone, loaderReload, digitalRst} = ev[2:0];
   mac_model u_mac (.*);
   vphy_autoneg #(.SOFT_RST_CYCLES(8)) dut (.*);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic stop_test();
      $display("mismatches=%0d check_count=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Model result from advertisement and strap copies
   task automatic check_run();
      logic [3:0] p, c;
      p = {ms[1] & ms[0], ms[1], ms[0], 1'b1};
      c = p & adv[3:0];
      if (c != 4'h0)
         chk({negComplete, pageReceived, partnerNegAble, partnerAbil, linkSpeed100,
              linkFullDuplex, linkPause, localAdv},
             {3'h7, p, c[3] | c[2], c[3] | (c[1] & !c[2]), pse[0], lad[3:0]});
      else
         chk({negComplete, pageReceived, partnerNegAble, partnerAbil, linkSpeed100,
              linkFullDuplex, linkPause, localAdv},
             {3'h6, ms[1] ? 4'h4 : 4'h1, ms[1], 2'h0, lad[3:0]});
   endtask
   // Pulse one restart source, wait bounded for the run
   task automatic run(input int k);
      int n;
      ms = {strapSpeed, strapDuplex};
      if (k == 0 || k == 3 || k == 4) begin
         adv = 15;
         lad = 15;
         pse = 0;
      end
      @(negedge core_clk) ev[k] = 1'b1;
      @(negedge core_clk) ev = 6'h00;
      if (k == 3 || k == 4)
         chk({globalSoftRst, ctrlSoftRst}, (k == 3) ? 14'h2 : 14'h1);
      // Soft resets restart only when the timer ends: see the old run drop first
      n = 0;
      while (n < 40 && pageReceived !== 1'b0) begin
         @(negedge core_clk);
         n++;
      end
      while (n < 80 && pageReceived !== 1'b1) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 80) begin
         mismatches++;
         stop_test();
      end
      @(negedge core_clk);
      check_run();
      chk({globalSoftRst, ctrlSoftRst}, 14'h0);
   endtask
   initial begin
      {resetn, ctrlSpeed100, ctrlFullDuplex, ev} = '0;
      {negEnable, strapSpeed, strapDuplex} = 3'h7;
      adv = 15;
      lad = 15;
      pse = 0;
      ms = 3;
      void'($urandom(21779));
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      chk(localAdv, 4'hF);
      repeat (6) @(negedge core_clk);
      check_run();
      for (i = 0; i < 16; i++) begin
         {strapSpeed, strapDuplex} = 2'($urandom % 4);
         repeat (3) @(negedge core_clk);
         pz = 2'($urandom % 4);
         u_mac.write_adv(4'(i), pz);
         lad = i;
         check_run();
         adv = i;
         pse = pz;
         run(5);
      end
      for (i = 0; i < 5; i++) begin
         u_mac.write_adv(4'h5 ^ 4'(i), 2'h1);
         adv = 5 ^ i;
         lad = adv;
         pse = 1;
         run(i);
      end
      negEnable = 1'b0;
      for (i = 0; i < 4; i++) begin
         {ctrlSpeed100, ctrlFullDuplex} = 2'(i);
         @(negedge core_clk);
         chk({linkSpeed100, linkFullDuplex}, 14'(i));
      end
      negEnable = 1'b1;
      run(5);
      stop_test();
   end
endmodule // tb
`default_nettype wire
